// ---- verilog/ssl_pkg.sv ----
// Shared constants and types for the soft strap and fast link-drop block
package ssl_pkg;
  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_CTRL_ONE = 8'h09;
  localparam logic [7:0] IDX_CTRL_THREE = 8'h0b;
  localparam logic [7:0] IDX_STATUS = 8'h20;
  localparam logic [7:0] IDX_MASK = 8'h21;
  localparam logic [7:0] IDX_LIVE = 8'h22;

  // Field positions in the first strap control register
  localparam int CFG_DONE_BIT = 15;
  // Field positions in the third strap control register
  localparam int POL_BIT = 6;
  localparam int SWAP_BIT = 5;
  localparam int BYP_BIT = 4;
  localparam int FLD_RECEIVE_ERROR_PIN_BIT = 3;
  localparam int FLD_MLT3_BIT = 2;
  localparam int FLD_SNR_BIT = 1;
  localparam int FLD_ENERGY_BIT = 0;
  localparam int STRAP_W = 7;

  // Status and mask layout
  localparam int ST_DROP_BIT = 0;
  localparam int ST_CFG_BIT = 1;
  localparam int ST_W = 2;

  // Reset values
  localparam logic [STRAP_W-1:0] CTRL_THREE_RST = 7'h00;
  localparam logic [ST_W-1:0] STATUS_RST = 2'h0;
  localparam logic [ST_W-1:0] MASK_RST = 2'h0;

  // Timing: measuring window of the occurrence counters
  localparam int CLK_PERIOD_NS = 40;
  localparam int WIN_NS = 10000;
  localparam int WIN_CYC = WIN_NS / CLK_PERIOD_NS;

  // Occurrence limits per window
  localparam int RECEIVE_ERROR_PIN_LIMIT = 32;
  localparam int MLT3_LIMIT = 20;
  localparam int SNR_LIMIT = 20;

  // Working strap values as latched after configuration
  typedef struct packed {
    logic pol;
    logic swap;
    logic byp;
    logic [3:0] fld;
  } ssl_strap_s;

  // Configuration-complete sequence
  typedef enum logic [1:0] {
    CFG_IDLE = 2'b00,
    CFG_RESET = 2'b01,
    CFG_LATCH = 2'b10
  } ssl_cfg_e;
endpackage

// ---- verilog/ssl_sync3.sv ----
// Three-stage synchroniser for an asynchronous level input
`timescale 1ns/1ps
module ssl_sync3 (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic din,
  output logic dout
);
  // Chain stages; the first is read by the second only
  logic s1_q, s2_q, s3_q;
  logic out_q, out_d;

  // Output follows once stages two and three agree
  always_comb begin
    out_d = out_q;
    if (s2_q == s3_q) begin
      out_d = s3_q;
    end
  end

  // Registers only
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
      out_q <= 1'b0;
    end else begin
      s1_q <= din;
      s2_q <= s1_q;
      s3_q <= s2_q;
      out_q <= out_d;
    end
  end

  assign dout = out_q;
endmodule

// ---- verilog/ssl_evt_window.sv ----
// Occurrence counter that fires when a limit is met inside one window
`timescale 1ns/1ps
module ssl_evt_window #(
  parameter int LIMIT = 20
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic enable,
  input wire logic win_end,
  input wire logic evt,
  output logic hit
);
  // Last count before the limit is reached
  localparam logic [5:0] LAST = 6'(LIMIT - 1);
  // Count parks here after the hit, so a window fires only once
  localparam logic [5:0] FULL = 6'(LIMIT);

  logic [5:0] cnt_q, cnt_d;
  logic hit_q, hit_d;

  // Count, clear at window edge; an event on the edge cycle is not counted, though it can still complete a hit
  always_comb begin
    hit_d = enable & evt & (cnt_q == LAST);
    cnt_d = cnt_q;
    if (!enable || win_end) begin
      cnt_d = 6'h00;
    end else if (evt && cnt_q != FULL) begin
      // Stop past the limit; parking on LAST would fire on every later event
      cnt_d = cnt_q + 6'h01;
    end
  end

  // Registers only
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= 6'h00;
      hit_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      hit_q <= hit_d;
    end
  end

  assign hit = hit_q;
endmodule

// ---- verilog/ssl_top.sv ----
// Soft strap register bank with fast link-drop supervisor on AHB-Lite
// Functional notes
// - Config-done gives reset pulse, then latches straps
// - Bits 15 to 7 read zero, ignore writes
// - Bit 6 inverts both pair polarities
// - Bit 5 swaps transmit and receive pairs
// - Bits 5 and 6 together enable mirroring
// - Bit 4 bypasses symbol coder, 5-bit MAC
// - Bypass: tx bit from test pin, rx on error
// - Bit 3: 32 receive errors per window drop
// - Bit 2: 20 line code violations drop
// - Bit 1: 20 low SNR crossings drop
// - Bit 0: energy loss drops link
// - Drop conditions combine as logical OR
`timescale 1ns/1ps
module ssl_top (
  input wire logic mclk,
  input wire logic arst_n,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  output logic irq,
  // Internal reset pulse to the configured functions
  output logic strap_reset,
  // Configured functions
  output logic polarity_invert,
  output logic pair_swap_select,
  output logic port_mirror,
  output logic symbol_code_bypass,
  // Symbol path extras
  input wire logic test_data_in_pin,
  input wire logic mac_rx_error,
  input wire logic rx_symbol_bit4,
  output logic tx_symbol_bit4,
  output logic receive_error_pin,
  // Fast link-down sources
  input wire logic mlt3_violation,
  input wire logic low_snr_crossing,
  input wire logic energy_loss,
  output logic link_drop
);
  // Reset release through two flops
  logic rst_meta_q, rst_sync_q;
  logic rst_n;

  // Bus address-phase capture
  logic wr_pend_q, wr_pend_d;
  logic [7:0] wr_idx_q, wr_idx_d;
  logic [31:0] hrdata_q, hrdata_d;

  // Software-visible registers
  logic cfg_done_q, cfg_done_d;
  logic [ssl_pkg::STRAP_W-1:0] ctrl_three_q, ctrl_three_d;
  logic [ssl_pkg::ST_W-1:0] status_q, status_d;
  logic [ssl_pkg::ST_W-1:0] mask_q, mask_d;
  logic irq_q, irq_d;

  // Config sequence and working straps
  ssl_pkg::ssl_cfg_e cfg_q, cfg_d;
  ssl_pkg::ssl_strap_s live_q, live_d;
  logic strap_reset_q, strap_reset_d;
  logic cfg_evt;

  // Window timer
  logic [7:0] win_cnt_q, win_cnt_d;
  logic win_end;

  // Datapath output flops
  logic pol_q, swap_q, mirror_q, byp_q;
  logic pol_d, swap_d, mirror_d, byp_d;
  logic tx_b4_q, tx_b4_d;
  logic receive_error_pin_pin_q, receive_error_pin_pin_d;
  logic drop_q, drop_d;

  // Synchronised pins and counter hits
  logic tdi_s, energy_loss_s;
  logic hit_receive_error_pin, hit_mlt3, hit_snr;
  logic wr_take;

  // Matches a bus address against a register index
  function automatic logic idx_hit(input logic [31:0] a, input logic [7:0] idx);
    idx_hit = (a[31:10] == 22'h00_0000) && (a[9:2] == idx);
  endfunction

  // Reset synchroniser
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end
  assign rst_n = rst_sync_q;

  // Asynchronous pins pass three synchroniser flops and an output flop
  ssl_sync3 u_sync_tdi (
    .clk(mclk),
    .rst_n(rst_n),
    .din(test_data_in_pin),
    .dout(tdi_s)
  );
  ssl_sync3 u_sync_energy (
    .clk(mclk),
    .rst_n(rst_n),
    .din(energy_loss),
    .dout(energy_loss_s)
  );

  // Data phase write happens one cycle after the address phase
  assign wr_take = wr_pend_q;

  // Register file next state
  always_comb begin
    wr_pend_d = hsel & hready & htrans[1] & hwrite;
    wr_idx_d = haddr[9:2];
    if (haddr[31:10] != 22'h00_0000) begin
      // Unmapped high addresses never hit a register
      wr_idx_d = 8'hff;
    end
    cfg_done_d = cfg_done_q;
    ctrl_three_d = ctrl_three_q;
    mask_d = mask_q;
    status_d = status_q;
    cfg_evt = 1'b0;
    if (wr_take) begin
      unique case (wr_idx_q)
        ssl_pkg::IDX_CTRL_ONE: begin
          cfg_done_d = hwdata[ssl_pkg::CFG_DONE_BIT];
          cfg_evt = hwdata[ssl_pkg::CFG_DONE_BIT];
        end
        ssl_pkg::IDX_CTRL_THREE: begin
          ctrl_three_d = hwdata[ssl_pkg::STRAP_W-1:0];
        end
        ssl_pkg::IDX_MASK: begin
          mask_d = hwdata[ssl_pkg::ST_W-1:0];
        end
        ssl_pkg::IDX_STATUS: begin
          // Write one to clear
          status_d = status_q & ~hwdata[ssl_pkg::ST_W-1:0];
        end
        default: begin
          // Unmapped or read-only: ignored
        end
      endcase
    end
    // Set wins over a clear in the same cycle
    if (drop_d) begin
      status_d[ssl_pkg::ST_DROP_BIT] = 1'b1;
    end
    if (cfg_q == ssl_pkg::CFG_LATCH) begin
      status_d[ssl_pkg::ST_CFG_BIT] = 1'b1;
    end
    irq_d = |(status_d & mask_d);
  end

  // Read data from next values, so a read right after a write sees it
  always_comb begin
    hrdata_d = 32'h0000_0000;
    if (hsel && hready && htrans[1] && !hwrite) begin
      if (idx_hit(haddr, ssl_pkg::IDX_CTRL_ONE)) begin
        hrdata_d[ssl_pkg::CFG_DONE_BIT] = cfg_done_d;
      end else if (idx_hit(haddr, ssl_pkg::IDX_CTRL_THREE)) begin
        hrdata_d[ssl_pkg::STRAP_W-1:0] = ctrl_three_d;
      end else if (idx_hit(haddr, ssl_pkg::IDX_STATUS)) begin
        hrdata_d[ssl_pkg::ST_W-1:0] = status_d;
      end else if (idx_hit(haddr, ssl_pkg::IDX_MASK)) begin
        hrdata_d[ssl_pkg::ST_W-1:0] = mask_d;
      end else if (idx_hit(haddr, ssl_pkg::IDX_LIVE)) begin
        // Working copy that actually steers the functions
        hrdata_d[ssl_pkg::STRAP_W-1:0] = live_d;
      end
    end
  end

  // Register file flops
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      wr_pend_q <= 1'b0;
      wr_idx_q <= 8'h00;
      hrdata_q <= 32'h0000_0000;
      cfg_done_q <= 1'b0;
      ctrl_three_q <= ssl_pkg::CTRL_THREE_RST;
      status_q <= ssl_pkg::STATUS_RST;
      mask_q <= ssl_pkg::MASK_RST;
      irq_q <= 1'b0;
    end else begin
      wr_pend_q <= wr_pend_d;
      wr_idx_q <= wr_idx_d;
      hrdata_q <= hrdata_d;
      cfg_done_q <= cfg_done_d;
      ctrl_three_q <= ctrl_three_d;
      status_q <= status_d;
      mask_q <= mask_d;
      irq_q <= irq_d;
    end
  end

  // Config sequence: reset pulse first, then latch
  always_comb begin
    cfg_d = cfg_q;
    live_d = live_q;
    strap_reset_d = 1'b0;
    unique case (cfg_q)
      ssl_pkg::CFG_IDLE: begin
        if (cfg_evt) begin
          cfg_d = ssl_pkg::CFG_RESET;
          strap_reset_d = 1'b1;
        end
      end
      ssl_pkg::CFG_RESET: begin
        cfg_d = ssl_pkg::CFG_LATCH;
      end
      ssl_pkg::CFG_LATCH: begin
        live_d = ctrl_three_q;
        cfg_d = ssl_pkg::CFG_IDLE;
      end
      default: begin
        // Illegal code recovers to idle
        cfg_d = ssl_pkg::CFG_IDLE;
      end
    endcase
  end

  // Config sequence flops
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_q <= ssl_pkg::CFG_IDLE;
      live_q <= ssl_pkg::CTRL_THREE_RST;
      strap_reset_q <= 1'b0;
    end else begin
      cfg_q <= cfg_d;
      live_q <= live_d;
      strap_reset_q <= strap_reset_d;
    end
  end

  // Free-running window timer, restarted by the strap reset
  always_comb begin
    win_end = (win_cnt_q == 8'(ssl_pkg::WIN_CYC - 1));
    if (win_end || strap_reset_q) begin
      win_cnt_d = 8'h00;
    end else begin
      win_cnt_d = win_cnt_q + 8'h01;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      win_cnt_q <= 8'h00;
    end else begin
      win_cnt_q <= win_cnt_d;
    end
  end

  ssl_evt_window #(.LIMIT(ssl_pkg::RECEIVE_ERROR_PIN_LIMIT)) u_win_receive_error_pin (
    .clk(mclk),
    .rst_n(rst_n),
    .enable(live_q.fld[ssl_pkg::FLD_RECEIVE_ERROR_PIN_BIT] & ~strap_reset_q),
    .win_end(win_end),
    .evt(mac_rx_error),
    .hit(hit_receive_error_pin)
  );
  ssl_evt_window #(.LIMIT(ssl_pkg::MLT3_LIMIT)) u_win_mlt3 (
    .clk(mclk),
    .rst_n(rst_n),
    .enable(live_q.fld[ssl_pkg::FLD_MLT3_BIT] & ~strap_reset_q),
    .win_end(win_end),
    .evt(mlt3_violation),
    .hit(hit_mlt3)
  );
  ssl_evt_window #(.LIMIT(ssl_pkg::SNR_LIMIT)) u_win_snr (
    .clk(mclk),
    .rst_n(rst_n),
    .enable(live_q.fld[ssl_pkg::FLD_SNR_BIT] & ~strap_reset_q),
    .win_end(win_end),
    .evt(low_snr_crossing),
    .hit(hit_snr)
  );

  // Function outputs from the working straps
  always_comb begin
    pol_d = live_q.pol;
    swap_d = live_q.swap;
    mirror_d = live_q.pol & live_q.swap;
    byp_d = live_q.byp;
    tx_b4_d = live_q.byp ? tdi_s : 1'b0;
    receive_error_pin_pin_d = live_q.byp ? rx_symbol_bit4 : mac_rx_error;
    drop_d = hit_receive_error_pin | hit_mlt3 | hit_snr |
      (live_q.fld[ssl_pkg::FLD_ENERGY_BIT] & energy_loss_s);
  end

  // Function output flops
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pol_q <= 1'b0;
      swap_q <= 1'b0;
      mirror_q <= 1'b0;
      byp_q <= 1'b0;
      tx_b4_q <= 1'b0;
      receive_error_pin_pin_q <= 1'b0;
      drop_q <= 1'b0;
    end else begin
      pol_q <= pol_d;
      swap_q <= swap_d;
      mirror_q <= mirror_d;
      byp_q <= byp_d;
      tx_b4_q <= tx_b4_d;
      receive_error_pin_pin_q <= receive_error_pin_pin_d;
      drop_q <= drop_d;
    end
  end

  // Zero-wait slave, always OKAY; hsize unused, word only
  assign hreadyout = rst_sync_q;
  assign hresp = 1'b0;
  assign hrdata = hrdata_q;
  assign irq = irq_q;
  assign strap_reset = strap_reset_q;
  assign polarity_invert = pol_q;
  assign pair_swap_select = swap_q;
  assign port_mirror = mirror_q;
  assign symbol_code_bypass = byp_q;
  assign tx_symbol_bit4 = tx_b4_q;
  assign receive_error_pin = receive_error_pin_pin_q;
  assign link_drop = drop_q;
endmodule

// ---- testbench/ssl_top_sva.sv ----
// Port checker for strap outputs, symbol path and link drop
`timescale 1ns/1ps
module ssl_chk (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic strap_reset,
  input wire logic polarity_invert,
  input wire logic pair_swap_select,
  input wire logic port_mirror,
  input wire logic symbol_code_bypass,
  input wire logic test_data_in_pin,
  input wire logic mac_rx_error,
  input wire logic rx_symbol_bit4,
  input wire logic tx_symbol_bit4,
  input wire logic receive_error_pin,
  input wire logic mlt3_violation,
  input wire logic low_snr_crossing,
  input wire logic energy_loss,
  input wire logic link_drop
);
  // Any counted event this cycle
  logic evt;
  assign evt = mac_rx_error | mlt3_violation | low_snr_crossing;
  // Single clock domain
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);
  property p_rst_pulse; strap_reset |=> !strap_reset; endproperty
  a_rst_pulse: assert property (p_rst_pulse)
    else $error("strap reset pulse too long");
  property p_late;
    ($changed(polarity_invert) || $changed(pair_swap_select) || $changed(symbol_code_bypass))
      |-> ($past(strap_reset, 2) || $past(strap_reset, 3) || $past(strap_reset, 4));
  endproperty
  a_late: assert property (p_late)
    else $error("strap output moved without reset pulse");
  property p_mirror; port_mirror == (polarity_invert && pair_swap_select); endproperty
  a_mirror: assert property (p_mirror)
    else $error("mirror output wrong");
  property p_rsv;
    (hready && htrans[1] && !hwrite && haddr == 32'h0000_002c) |=> hrdata[31:7] == 25'h0;
  endproperty
  a_rsv: assert property (p_rsv)
    else $error("reserved bits not zero");
  property p_byp_rx;
    symbol_code_bypass && $past(symbol_code_bypass) && $past(hready)
      |-> receive_error_pin == $past(rx_symbol_bit4);
  endproperty
  a_byp_rx: assert property (p_byp_rx)
    else $error("error pin not carrying rx symbol bit");
  property p_norm;
    !symbol_code_bypass && !$past(symbol_code_bypass) && $past(hready)
      |-> !tx_symbol_bit4 && receive_error_pin == $past(mac_rx_error);
  endproperty
  a_norm: assert property (p_norm)
    else $error("symbol path wrong outside bypass");
  property p_byp_tx;
    (symbol_code_bypass && $stable(test_data_in_pin))[*7] |-> tx_symbol_bit4 == test_data_in_pin;
  endproperty
  a_byp_tx: assert property (p_byp_tx)
    else $error("tx symbol bit not from test pin");
  property p_cause;
    (!energy_loss)[*8] ##0 (link_drop && $past(hready))
      |-> $past(evt) || $past(evt, 2) || $past(evt, 3);
  endproperty
  a_cause: assert property (p_cause)
    else $error("link drop without event");
endmodule

bind ssl_top ssl_chk i_ssl_chk (.mclk(mclk), .arst_n(arst_n), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hready(hready), .hrdata(hrdata), .strap_reset(strap_reset),
  .polarity_invert(polarity_invert), .pair_swap_select(pair_swap_select),
  .port_mirror(port_mirror), .symbol_code_bypass(symbol_code_bypass),
  .test_data_in_pin(test_data_in_pin), .mac_rx_error(mac_rx_error),
  .rx_symbol_bit4(rx_symbol_bit4), .tx_symbol_bit4(tx_symbol_bit4),
  .receive_error_pin(receive_error_pin), .mlt3_violation(mlt3_violation),
  .low_snr_crossing(low_snr_crossing), .energy_loss(energy_loss), .link_drop(link_drop));

// ---- testbench/ssl_host.sv ----
// Processor model setting straps over AHB-Lite
`timescale 1ns/1ps
module ssl_host (
  input wire logic mclk,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  output logic hsel,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata
);
  logic rdy_n; // Ready just before an edge
  logic [31:0] rd_n; // Read data just before an edge
  // Idle bus from time zero
  initial begin
    {hsel, haddr, htrans, hwrite, hwdata} = '0;
    hsize = 3'h2;
  end
  // Pre-edge copies, so the slave's own edge update never races us
  always @(negedge mclk) begin
    rdy_n <= hready;
    rd_n <= hrdata;
  end
  // Single word transfer; waits on ready with no assumed latency
  task automatic xfer(input logic w, input logic [31:0] a, d, output logic [31:0] r);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    @(posedge mclk);
    while (rdy_n !== 1'b1) @(posedge mclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge mclk);
    while (rdy_n !== 1'b1) @(posedge mclk);
    r = rd_n;
  endtask
  // Write, answer dropped
  task automatic wr(input logic [31:0] a, d);
    logic [31:0] r;
    xfer(1'b1, a, d, r);
  endtask
  // Read
  task automatic rd(input logic [31:0] a, output logic [31:0] r);
    xfer(1'b0, a, 32'h0, r);
  endtask
  task automatic cfg(input logic [6:0] s);
    // callers may also set bypass for 5-bit MAC mode
    wr(32'h0000_002c, {25'h0, s});
    wr(32'h0000_0024, 32'h0000_8000);
  endtask
endmodule

// ---- testbench/tb.sv ----
// Self-checking bench for strap bank and link-drop supervisor
`timescale 1ns/1ps
module tb;
  logic mclk, arst_n, hsel, hwrite, hreadyout, hresp, irq, strap_reset;
  logic [31:0] haddr, hwdata, hrdata, r;
  logic [1:0] htrans;
  logic [2:0] hsize, evv; // evv: rx error, line code, low SNR
  logic polarity_invert, pair_swap_select, port_mirror, symbol_code_bypass;
  logic tpin, rx4, tx_symbol_bit4, receive_error_pin, energy_loss, link_drop;
  logic [15:0] lf; // Random state
  logic [6:0] s;
  int error_cnt, checks_done, cyc, t0, drops, d0, pulses;
  int lim [3] = '{ssl_pkg::RECEIVE_ERROR_PIN_LIMIT, ssl_pkg::MLT3_LIMIT, ssl_pkg::SNR_LIMIT};
  logic [6:0] corner [4] = '{7'h60, 7'h10, 7'h40, 7'h20};
  logic [31:0] amap [6] = '{32'h0000_0024, 32'h0000_002c, 32'h0000_0080,
    32'h0000_0084, 32'h0000_0088, 32'h0000_0040};
  // 25 MHz clock
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  ssl_top i_ssl_top (.mclk(mclk), .arst_n(arst_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .irq(irq),
    .strap_reset(strap_reset), .polarity_invert(polarity_invert),
    .pair_swap_select(pair_swap_select), .port_mirror(port_mirror),
    .symbol_code_bypass(symbol_code_bypass), .test_data_in_pin(tpin),
    .mac_rx_error(evv[0]), .rx_symbol_bit4(rx4), .tx_symbol_bit4(tx_symbol_bit4),
    .receive_error_pin(receive_error_pin), .mlt3_violation(evv[1]),
    .low_snr_crossing(evv[2]), .energy_loss(energy_loss), .link_drop(link_drop));
  ssl_host i_ssl_host (.mclk(mclk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
  // Random step
  function automatic logic [15:0] nx(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  // Compare and count
  task automatic chk(input string nm, input logic [31:0] e, g);
    checks_done++;
    if (g !== e) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Verdict and end
  task automatic complete_run();
    if (error_cnt == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // Random rx symbol bit and error pulses
  task automatic tick(input int n);
    repeat (n) begin
      @(posedge mclk);
      lf = nx(lf);
      rx4 <= lf[0];
      evv[0] <= lf[1];
    end
  endtask
  // n back-to-back events on source k, then settle
  task automatic burst(input int k, n);
    repeat (n) begin
      @(posedge mclk);
      evv <= 3'h1 << k;
    end
    @(posedge mclk);
    evv <= 3'h0;
    repeat (4) @(posedge mclk);
  endtask
  // Wait to a cycle offset from the last configuration
  task automatic wait_to(input int t);
    while (cyc - t0 < t) @(posedge mclk);
  endtask
  // Drop and strap reset pulses counted between edges, where they are settled
  always @(negedge mclk) begin
    if (link_drop === 1'b1) drops <= drops + 1;
    if (strap_reset === 1'b1) pulses <= pulses + 1;
  end
  // Cycle ceiling against a hang
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 10000) begin
      error_cnt++;
      complete_run();
    end
  end
  // Main sequence
  initial begin
    arst_n = 1'b0;
    {tpin, rx4, evv, energy_loss} = '0;
    lf = 16'h4380;
    repeat (4) @(posedge mclk);
    arst_n <= 1'b1;
    foreach (amap[i]) begin
      i_ssl_host.rd(amap[i], r);
      chk("reset value", 32'h0, r);
      chk("okay", 32'h0, hresp);
    end
    i_ssl_host.wr(32'h0000_002c, 32'hffff_ffff);
    i_ssl_host.rd(32'h0000_002c, r);
    chk("ctrl three", 32'h0000_007f, r);
    i_ssl_host.rd(32'h0000_0088, r);
    chk("live before done", 32'h0, r);
    // Corner straps first, then random ones
    tpin <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      lf = nx(lf);
      s = (i < 4) ? corner[i] : lf[6:0];
      i_ssl_host.cfg(s);
      tick(8);
      chk("polarity", s[6], polarity_invert);
      chk("swap", s[5], pair_swap_select);
      chk("mirror", s[6] & s[5], port_mirror);
      chk("bypass", s[4], symbol_code_bypass);
      chk("tx bit", s[4], tx_symbol_bit4);
      i_ssl_host.rd(32'h0000_0088, r);
      chk("live", {25'h0, s}, r);
    end
    @(posedge mclk);
    evv <= 3'h0;
    chk("reset pulses", 8, pulses);
    i_ssl_host.rd(32'h0000_0024, r);
    chk("done bit", 32'h0000_8000, r);
    i_ssl_host.rd(32'h0000_0080, r);
    chk("status", 32'h0000_0002, r);
    i_ssl_host.wr(32'h0000_0084, 32'h0000_0003);
    repeat (2) @(posedge mclk);
    chk("irq on", 1'b1, irq);
    i_ssl_host.wr(32'h0000_0080, 32'h0000_0002);
    repeat (2) @(posedge mclk);
    chk("irq off", 1'b0, irq);
    // Three counters enabled together, two windows each
    i_ssl_host.cfg(7'h0e);
    t0 = cyc;
    for (int k = 0; k < 3; k++) begin
      wait_to(2 * k * ssl_pkg::WIN_CYC + 20);
      d0 = drops;
      burst(k, lim[k] - 1);
      chk("under limit", d0, drops);
      wait_to((2 * k + 1) * ssl_pkg::WIN_CYC + 20);
      burst(k, lim[k] - 1);
      chk("fresh window", d0, drops);
      burst(k, 1);
      chk("limit hit", d0 + 1, drops);
      burst(k, 1);
      chk("one per window", d0 + 1, drops);
    end
    chk("irq drop", 1'b1, irq);
    i_ssl_host.wr(32'h0000_0080, 32'h0000_0003);
    i_ssl_host.cfg(7'h01);
    energy_loss <= 1'b1;
    repeat (12) @(posedge mclk);
    chk("energy drop", 1'b1, link_drop);
    energy_loss <= 1'b0;
    repeat (12) @(posedge mclk);
    // All drop sources off; nothing may drop
    i_ssl_host.cfg(7'h70);
    d0 = drops;
    for (int k = 0; k < 3; k++) burst(k, 32);
    energy_loss <= 1'b1;
    repeat (12) @(posedge mclk);
    energy_loss <= 1'b0;
    repeat (12) @(posedge mclk);
    chk("disabled", d0, drops);
    chk("mirror on", 1'b1, port_mirror);
    // Second reset mid-run
    arst_n <= 1'b0;
    repeat (2) @(posedge mclk);
    arst_n <= 1'b1;
    i_ssl_host.rd(32'h0000_0088, r);
    chk("live after reset", 32'h0, r);
    complete_run();
  end
endmodule
